// *** lcdsc_pkg.sv ***
// lcdsc_pkg: register map, field positions and reset values of the display supply control block.
// assumes a 32-bit AXI4-Lite register bus with one aligned word per register.
`default_nettype none
package lcdsc_pkg;
  // register byte offsets
  localparam logic [7:0] DISP_CTRL_ONE_OFS = 8'h00;
  localparam logic [7:0] DISP_CTRL_TWO_OFS = 8'h04;
  localparam logic [7:0] SUPPLY_CTRL_OFS = 8'h08;
  localparam logic [7:0] REG_CTRL_OFS = 8'h0C;
  localparam logic [7:0] DISP_STATUS_OFS = 8'h10;
  // display control one fields
  localparam int DISP_EN_BIT = 0;
  localparam int DUTY_LSB = 1;
  localparam int FRAME_DIV_LSB = 4;
  localparam int BIAS_MODE_BIT = 7;
  // display control two fields
  localparam int FRAME_IRQ_EN_BIT = 0;
  localparam int BLINK_RATE_LSB = 1;
  // supply control fields
  localparam int SUPPLY_SEL_LSB = 0;
  localparam int REF_LEVEL_BIT = 2;
  localparam int BYPASS_BIT = 3;
  localparam int PUMP_EN_BIT = 4;
  // regulator control fields
  localparam int REG_EN_BIT = 0;
  localparam int TRIM_LSB = 1;
  localparam int TRIM_DOWN_BIT = 5;
  // status fields
  localparam int FRAME_FLAG_BIT = 0;
  localparam int SWITCH_LSB = 1;
  localparam int BUF_EN_BIT = 4;
  localparam int BIAS_ONE_SRC_LSB = 5;
  // reset values
  localparam logic [2:0] DUTY_RST = 3'h3;
  localparam logic BIAS_MODE_RST = 1'b0;
  localparam logic [2:0] FRAME_DIV_RST = 3'h0;
  localparam logic [2:0] BLINK_RATE_RST = 3'h0;
  localparam logic [1:0] SUPPLY_SEL_RST = 2'h3;
  localparam logic [3:0] TRIM_RST = 4'h0;
  // supply source codes
  localparam logic [1:0] SEL_CORE_TWO = 2'h0;
  localparam logic [1:0] SEL_CORE_THREE = 2'h1;
  localparam logic [1:0] SEL_PANEL_PIN = 2'h2;
  localparam logic [1:0] SEL_EXTERNAL = 2'h3;
  // trim: 1.5 % per count, at most 12 % either way
  localparam int TRIM_STEP_TENTHS = 15;
  localparam int TRIM_LIMIT_TENTHS = 120;
  localparam logic [3:0] TRIM_MAX = 4'(TRIM_LIMIT_TENTHS / TRIM_STEP_TENTHS);
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // bias level one source codes
  typedef enum logic [1:0] {
    LCDSC_B1_EXTERNAL = 2'h0,
    LCDSC_B1_TWO_THIRDS = 2'h1,
    LCDSC_B1_FULL_PIN = 2'h2,
    LCDSC_B1_REGULATED = 2'h3
  } lcdsc_bias_src_t;
  // bus phases
  typedef enum logic [1:0] {
    LCDSC_IDLE = 2'b01,
    LCDSC_RESP = 2'b10
  } lcdsc_phase_t;
endpackage : lcdsc_pkg
`default_nettype wire

// *** lcdsc_supply_ctrl.sv ***
// lcdsc_supply_ctrl: supply switch decode, bias routing, reset defaults and frame flag,
// with the registers on an AXI4-Lite slave.
// assumes one clock, all inputs synchronous to it, and the analog switches outside.
`timescale 1ns/1ps
`default_nettype none
module lcdsc_supply_ctrl
  import lcdsc_pkg::*;
#(
  parameter int FRAME_BASE = 4096,
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // axi4-lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // supply switches and bias routing
  output logic supplySwitchA,
  output logic supplySwitchB,
  output logic supplySwitchC,
  output logic refBufferEnable,
  output logic panelSupplyOeN,
  output logic [1:0] biasOneSource,
  output logic trplerScale,
  output logic regulatedToBiasOne,
  output logic refHighTarget,
  output logic [3:0] trimSteps,
  output logic trimDown,
  output logic pumpOn,
  output logic biasTwoInternal,
  output logic biasTwoFromCore,
  output logic biasThreeFromCore,
  // panel drivers and timing settings
  output logic displayEnable,
  output logic driversHiZ,
  output logic [2:0] dutySel,
  output logic biasMode,
  output logic [2:0] frameClockDiv,
  output logic [2:0] blinkRate,
  // frame event
  output logic frameIrq
);

  typedef struct packed {
    lcdsc_phase_t wPhase;
    lcdsc_phase_t rPhase;
    logic awHeld;
    logic wHeld;
    logic [ADDR_W-1:0] wAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic awReady;
    logic wReady;
    logic arReady;
    logic [1:0] bResp;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic dispEn;
    logic [2:0] duty;
    logic biasSel;
    logic [2:0] frameDiv;
    logic irqEn;
    logic [2:0] blink;
    logic [1:0] supplySel;
    logic refLevel;
    logic bypass;
    logic pumpEn;
    logic regEn;
    logic [3:0] trim;
    logic trimDn;
    logic frameFlag;
    logic [23:0] frameCnt;
    logic swA;
    logic swB;
    logic swC;
    logic bufEn;
    lcdsc_bias_src_t b1Src;
    logic irq;
  } lcdsc_state_t;

  lcdsc_state_t st_r;
  lcdsc_state_t st_nxt;

  // frame period grows by powers of two with the divider setting
  function automatic logic [23:0] framePeriod(input logic [2:0] div);
    framePeriod = 24'(FRAME_BASE) << div;
  endfunction : framePeriod

  // bias level one source from ref level, bypass, switch c and regulator
  function automatic lcdsc_bias_src_t biasOneFrom(input logic lvl, input logic byp,
                                                  input logic sw3, input logic reg1);
    if (reg1) begin
      biasOneFrom = LCDSC_B1_REGULATED;
    end else if (sw3) begin
      biasOneFrom = lvl ? LCDSC_B1_FULL_PIN : LCDSC_B1_TWO_THIRDS;
    end else begin
      biasOneFrom = LCDSC_B1_EXTERNAL;
    end
    if (byp && sw3 && !lvl) begin
      // unbuffered path has no divider, so the pin goes straight through
      biasOneFrom = reg1 ? LCDSC_B1_REGULATED : LCDSC_B1_FULL_PIN;
    end
  endfunction : biasOneFrom

  always_comb begin
    logic wrHit;
    logic frameEvt;
    logic flagClr;
    logic [7:0] wOfs;
    logic [7:0] rOfs;
    logic [31:0] rWord;
    logic rHit;
    wrHit = 1'b0;
    frameEvt = 1'b0;
    flagClr = 1'b0;
    wOfs = 8'(st_r.wAddr);
    rOfs = 8'(araddr);
    rWord = 32'h0;
    rHit = 1'b1;
    st_nxt = st_r;

    // write address and data taken in either order
    if (awvalid && st_r.awReady) begin
      st_nxt.awHeld = 1'b1;
      st_nxt.wAddr = awaddr;
    end
    if (wvalid && st_r.wReady) begin
      st_nxt.wHeld = 1'b1;
      st_nxt.wData = wdata;
      st_nxt.wStrb = wstrb;
    end
    unique case (st_r.wPhase)
      LCDSC_IDLE: begin
        if (st_r.awHeld && st_r.wHeld) begin
          wrHit = 1'b1;
          st_nxt.awHeld = 1'b0;
          st_nxt.wHeld = 1'b0;
          st_nxt.wPhase = LCDSC_RESP;
          st_nxt.bResp = RESP_OKAY;
        end
      end
      LCDSC_RESP: begin
        if (bready) begin
          st_nxt.wPhase = LCDSC_IDLE;
        end
      end
    endcase
    st_nxt.awReady = !st_nxt.awHeld && (st_nxt.wPhase == LCDSC_IDLE);
    st_nxt.wReady = !st_nxt.wHeld && (st_nxt.wPhase == LCDSC_IDLE);

    // register writes; every field sits in the low byte lane
    if (wrHit) begin
      if (!st_r.wStrb[0]) begin
        // nothing to store without lane zero
      end else if (wOfs == DISP_CTRL_ONE_OFS) begin
        st_nxt.dispEn = st_r.wData[DISP_EN_BIT];
        st_nxt.duty = st_r.wData[DUTY_LSB +: 3];
        st_nxt.frameDiv = st_r.wData[FRAME_DIV_LSB +: 3];
        st_nxt.biasSel = st_r.wData[BIAS_MODE_BIT];
      end else if (wOfs == DISP_CTRL_TWO_OFS) begin
        st_nxt.irqEn = st_r.wData[FRAME_IRQ_EN_BIT];
        st_nxt.blink = st_r.wData[BLINK_RATE_LSB +: 3];
      end else if (wOfs == SUPPLY_CTRL_OFS) begin
        st_nxt.supplySel = st_r.wData[SUPPLY_SEL_LSB +: 2];
        st_nxt.refLevel = st_r.wData[REF_LEVEL_BIT];
        st_nxt.bypass = st_r.wData[BYPASS_BIT];
        st_nxt.pumpEn = st_r.wData[PUMP_EN_BIT];
      end else if (wOfs == REG_CTRL_OFS) begin
        st_nxt.regEn = st_r.wData[REG_EN_BIT];
        // trim saturates at the largest legal step count
        st_nxt.trim = (st_r.wData[TRIM_LSB +: 4] > TRIM_MAX) ? TRIM_MAX
                      : st_r.wData[TRIM_LSB +: 4];
        st_nxt.trimDn = st_r.wData[TRIM_DOWN_BIT];
      end else if (wOfs == DISP_STATUS_OFS) begin
        flagClr = st_r.wData[FRAME_FLAG_BIT];
      end else begin
        st_nxt.bResp = RESP_SLVERR;
      end
    end

    // frame events only while the display runs
    if (!st_r.dispEn) begin
      st_nxt.frameCnt = 24'h0;
    end else if (st_r.frameCnt >= framePeriod(st_r.frameDiv) - 24'h1) begin
      st_nxt.frameCnt = 24'h0;
      frameEvt = 1'b1;
    end else begin
      st_nxt.frameCnt = st_r.frameCnt + 24'h1;
    end
    if (frameEvt) begin
      st_nxt.frameFlag = 1'b1;
    end else if (flagClr) begin
      st_nxt.frameFlag = 1'b0;
    end

    // read channel
    unique case (st_r.rPhase)
      LCDSC_IDLE: begin
        if (arvalid) begin
          if (rOfs == DISP_CTRL_ONE_OFS) begin
            rWord[DISP_EN_BIT] = st_r.dispEn;
            rWord[DUTY_LSB +: 3] = st_r.duty;
            rWord[FRAME_DIV_LSB +: 3] = st_r.frameDiv;
            rWord[BIAS_MODE_BIT] = st_r.biasSel;
          end else if (rOfs == DISP_CTRL_TWO_OFS) begin
            rWord[FRAME_IRQ_EN_BIT] = st_r.irqEn;
            rWord[BLINK_RATE_LSB +: 3] = st_r.blink;
          end else if (rOfs == SUPPLY_CTRL_OFS) begin
            rWord[SUPPLY_SEL_LSB +: 2] = st_r.supplySel;
            rWord[REF_LEVEL_BIT] = st_r.refLevel;
            rWord[BYPASS_BIT] = st_r.bypass;
            rWord[PUMP_EN_BIT] = st_r.pumpEn;
          end else if (rOfs == REG_CTRL_OFS) begin
            rWord[REG_EN_BIT] = st_r.regEn;
            rWord[TRIM_LSB +: 4] = st_r.trim;
            rWord[TRIM_DOWN_BIT] = st_r.trimDn;
          end else if (rOfs == DISP_STATUS_OFS) begin
            rWord[FRAME_FLAG_BIT] = st_r.frameFlag;
            rWord[SWITCH_LSB +: 3] = {st_r.swC, st_r.swB, st_r.swA};
            rWord[BUF_EN_BIT] = st_r.bufEn;
            rWord[BIAS_ONE_SRC_LSB +: 2] = st_r.b1Src;
          end else begin
            rHit = 1'b0;
          end
          st_nxt.rData = rWord;
          st_nxt.rResp = rHit ? RESP_OKAY : RESP_SLVERR;
          st_nxt.rPhase = LCDSC_RESP;
        end
      end
      LCDSC_RESP: begin
        if (rready) begin
          st_nxt.rPhase = LCDSC_IDLE;
        end
      end
    endcase
    st_nxt.arReady = (st_nxt.rPhase == LCDSC_IDLE);

    // supply switch decode from the next settings so outputs stay registered
    st_nxt.swA = (st_nxt.supplySel == SEL_CORE_TWO);
    st_nxt.swB = (st_nxt.supplySel == SEL_CORE_THREE);
    st_nxt.swC = (st_nxt.supplySel == SEL_PANEL_PIN);
    st_nxt.bufEn = !st_nxt.bypass && st_nxt.swC;
    st_nxt.b1Src = biasOneFrom(st_nxt.refLevel, st_nxt.bypass, st_nxt.swC, st_nxt.regEn);
    st_nxt.irq = st_nxt.frameFlag && st_nxt.irqEn;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
      st_r.wPhase <= LCDSC_IDLE;
      st_r.rPhase <= LCDSC_IDLE;
      st_r.awReady <= 1'b1;
      st_r.wReady <= 1'b1;
      st_r.arReady <= 1'b1;
      st_r.dispEn <= 1'b0;
      st_r.duty <= DUTY_RST;
      st_r.biasSel <= BIAS_MODE_RST;
      st_r.frameDiv <= FRAME_DIV_RST;
      st_r.blink <= BLINK_RATE_RST;
      st_r.supplySel <= SUPPLY_SEL_RST;
      st_r.bypass <= 1'b0;
      st_r.pumpEn <= 1'b0;
      st_r.regEn <= 1'b0;
      st_r.trim <= TRIM_RST;
      st_r.b1Src <= LCDSC_B1_EXTERNAL;
    end else begin
      st_r <= st_nxt;
    end
  end

  // bus outputs
  assign awready = st_r.awReady;
  assign wready = st_r.wReady;
  assign bvalid = (st_r.wPhase == LCDSC_RESP);
  assign bresp = st_r.bResp;
  assign arready = st_r.arReady;
  assign rvalid = (st_r.rPhase == LCDSC_RESP);
  assign rdata = st_r.rData;
  assign rresp = st_r.rResp;
  // supply and bias outputs
  assign supplySwitchA = st_r.swA;
  assign supplySwitchB = st_r.swB;
  assign supplySwitchC = st_r.swC;
  assign refBufferEnable = st_r.bufEn;
  // pin floats unless the buffer drives it
  assign panelSupplyOeN = !st_r.bufEn;
  assign biasOneSource = st_r.b1Src;
  assign trplerScale = st_r.refLevel;
  assign regulatedToBiasOne = st_r.regEn;
  assign refHighTarget = st_r.refLevel;
  assign trimSteps = st_r.trim;
  assign trimDown = st_r.trimDn;
  // core supply without the pump is illegal; software keeps the pump on then
  assign pumpOn = st_r.pumpEn;
  assign biasTwoInternal = st_r.pumpEn;
  assign biasTwoFromCore = st_r.swA;
  assign biasThreeFromCore = st_r.swB;
  assign displayEnable = st_r.dispEn;
  assign driversHiZ = !st_r.dispEn;
  assign dutySel = st_r.duty;
  assign biasMode = st_r.biasSel;
  assign frameClockDiv = st_r.frameDiv;
  assign blinkRate = st_r.blink;
  assign frameIrq = st_r.irq;

endmodule : lcdsc_supply_ctrl
`default_nettype wire

// *** lcdsc_supply_ctrl_checker.sv ***
// checker: port relations of lcdsc_supply_ctrl
// assumes one clock clk and async low reset nrst
`timescale 1ns/1ps
`default_nettype none
module lcdsc_supply_ctrl_checker
  import lcdsc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // supply and bias
  input wire logic supplySwitchA,
  input wire logic supplySwitchB,
  input wire logic supplySwitchC,
  input wire logic refBufferEnable,
  input wire logic panelSupplyOeN,
  input wire logic [1:0] biasOneSource,
  input wire logic trplerScale,
  input wire logic regulatedToBiasOne,
  input wire logic refHighTarget,
  input wire logic [3:0] trimSteps,
  input wire logic pumpOn,
  input wire logic biasTwoInternal,
  input wire logic biasTwoFromCore,
  input wire logic biasThreeFromCore,
  // panel settings
  input wire logic displayEnable,
  input wire logic driversHiZ,
  input wire logic [2:0] dutySel,
  input wire logic biasMode,
  input wire logic [2:0] frameClockDiv,
  input wire logic [2:0] blinkRate
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_sw_onehot: assert property ($onehot0({supplySwitchA, supplySwitchB, supplySwitchC}))
    else $error("several supply switches closed");
  chk_buf_on: assert property (refBufferEnable |-> supplySwitchC && !panelSupplyOeN)
    else $error("buffer on without switch c");
  chk_pin_float: assert property (!supplySwitchC |-> panelSupplyOeN && !refBufferEnable)
    else $error("panel pin driven with switch c open");
  chk_reg_src: assert property (regulatedToBiasOne |-> biasOneSource == 2'h3)
    else $error("regulated reference not on bias one");
  chk_ext_src: assert property (!regulatedToBiasOne && !supplySwitchC
    |-> biasOneSource == 2'h0)
    else $error("bias one not external");
  chk_scale_ref: assert property (trplerScale == refHighTarget)
    else $error("scale and target disagree");
  chk_core_taps: assert property (biasTwoFromCore == supplySwitchA
    && biasThreeFromCore == supplySwitchB)
    else $error("core taps wrong");
  chk_pump_two: assert property (biasTwoInternal == pumpOn)
    else $error("bias two not with pump");
  chk_drv_hiz: assert property (driversHiZ != displayEnable)
    else $error("drivers float state wrong");
  chk_trim_max: assert property (trimSteps <= TRIM_MAX)
    else $error("trim beyond limit");
  chk_rst_dflt: assert property (disable iff (1'b0) $rose(nrst) |-> dutySel == DUTY_RST
    && biasMode == BIAS_MODE_RST && frameClockDiv == FRAME_DIV_RST && blinkRate == BLINK_RATE_RST
    && !displayEnable && !pumpOn && !regulatedToBiasOne && !supplySwitchC)
    else $error("reset defaults wrong");
endmodule : lcdsc_supply_ctrl_checker
bind lcdsc_supply_ctrl lcdsc_supply_ctrl_checker chk_i (.clk, .nrst, .supplySwitchA,
  .supplySwitchB, .supplySwitchC, .refBufferEnable, .panelSupplyOeN, .biasOneSource,
  .trplerScale, .regulatedToBiasOne, .refHighTarget, .trimSteps, .pumpOn, .biasTwoInternal,
  .biasTwoFromCore, .biasThreeFromCore, .displayEnable, .driversHiZ, .dutySel, .biasMode,
  .frameClockDiv, .blinkRate);
`default_nettype wire

// *** lcdsc_panel_model.sv ***
// partner model: panel bias supplies outside the block
// assumes switch and pump levels straight from the block
`timescale 1ns/1ps
`default_nettype none
module lcdsc_panel_model (
  // supply state from the block
  input wire logic supplySwitchA,
  input wire logic supplySwitchB,
  input wire logic supplySwitchC,
  input wire logic pumpOn,
  input wire logic regulatedToBiasOne,
  // duties of the outside supply
  output logic extAll,
  output logic extThree,
  output logic badCore
);
  logic noSwitch;
  assign noSwitch = !supplySwitchA && !supplySwitchB && !supplySwitchC;
  // no switch closed and no pump: outside feeds every level
  assign extAll = noSwitch && !pumpOn;
  // regulator on: level one must stay undriven from outside
  assign extThree = noSwitch && pumpOn && !regulatedToBiasOne;
  // core supply without pump is a software fault
  assign badCore = (supplySwitchA || supplySwitchB) && !pumpOn;
endmodule : lcdsc_panel_model
`default_nettype wire

// *** lcdsc_supply_ctrl_tb_top.sv ***
// bench: lcdsc_supply_ctrl driven over axi4-lite
// assumes FRAME_BASE cut to 4 so frame events come fast
`timescale 1ns/1ps
`default_nettype none
module lcdsc_supply_ctrl_tb_top
  import lcdsc_pkg::*;
;
  logic clk, nrst, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, supplySwitchA, supplySwitchB, supplySwitchC, refBufferEnable;
  logic panelSupplyOeN, trplerScale, regulatedToBiasOne, refHighTarget, trimDown, pumpOn;
  logic biasTwoInternal, biasTwoFromCore, biasThreeFromCore, displayEnable, driversHiZ;
  logic biasMode, frameIrq, extAll, extThree, badCore;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rdv;
  logic [3:0] wstrb, trimSteps;
  logic [2:0] awprot, arprot, dutySel, frameClockDiv, blinkRate;
  logic [1:0] bresp, rresp, biasOneSource, rsp;
  int fail_count, n_checks;
  lcdsc_supply_ctrl #(.FRAME_BASE(4)) uut (.clk, .nrst, .awvalid, .awready, .awaddr, .awprot,
    .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .arprot, .rvalid, .rready, .rdata, .rresp, .supplySwitchA, .supplySwitchB, .supplySwitchC,
    .refBufferEnable, .panelSupplyOeN, .biasOneSource, .trplerScale, .regulatedToBiasOne,
    .refHighTarget, .trimSteps, .trimDown, .pumpOn, .biasTwoInternal, .biasTwoFromCore,
    .biasThreeFromCore, .displayEnable, .driversHiZ, .dutySel, .biasMode, .frameClockDiv,
    .blinkRate, .frameIrq);
  lcdsc_panel_model panel (.supplySwitchA, .supplySwitchB, .supplySwitchC, .pumpOn,
    .regulatedToBiasOne, .extAll, .extThree, .badCore);
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
      fail_count++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit ad, dd;
    ad = 0;
    dd = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge clk);
      if (!ad && awready === 1'b1) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (!dd && wready === 1'b1) begin
        dd = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    // one idle edge, so a following call never lowers and raises bready in one step
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    // same idle edge as the write side
    @(posedge clk);
  endtask : rd
  task automatic t_reset;
    chk("drivers", {displayEnable, driversHiZ}, 2'b01);
    chk("duty bias", {dutySel, biasMode}, {DUTY_RST, BIAS_MODE_RST});
    chk("div blink", {frameClockDiv, blinkRate}, {FRAME_DIV_RST, BLINK_RATE_RST});
    chk("pump rst", pumpOn, 1'b0);
    rd(SUPPLY_CTRL_OFS, rdv, rsp);
    chk("supply reg", rdv, {30'h0, SUPPLY_SEL_RST});
    chk("switches", {supplySwitchA, supplySwitchB, supplySwitchC, panelSupplyOeN}, 4'h1);
  endtask : t_reset
  task automatic t_supply;
    logic [2:0] e;
    for (int i = 0; i < 4; i++) begin
      wr(SUPPLY_CTRL_OFS, 32'h10 | i, rsp);
      e = (i == 3) ? 3'h0 : 3'h1 << i;
      chk("switch set", {supplySwitchC, supplySwitchB, supplySwitchA}, e);
      chk("core taps", {biasThreeFromCore, biasTwoFromCore}, e[1:0]);
      chk("buffer", {refBufferEnable, panelSupplyOeN}, {e[2], !e[2]});
      chk("pump", {pumpOn, biasTwoInternal}, 2'h3);
      chk("outside", {extAll, extThree, badCore}, {1'b0, i == 3, 1'b0});
      rd(DISP_STATUS_OFS, rdv, rsp);
      chk("switch status", rdv[3:1], e);
    end
    wr(SUPPLY_CTRL_OFS, 32'h3, rsp);
    chk("no pump", {extAll, pumpOn, biasTwoInternal}, 3'h4);
  endtask : t_supply
  task automatic t_bias;
    for (int i = 0; i < 4; i++) begin
      wr(SUPPLY_CTRL_OFS, 32'h12 | (i << 2), rsp); // panel pin, ref i[0], bypass i[1]
      chk("scale", {trplerScale, refHighTarget}, {2{i[0]}});
      chk("bias one", biasOneSource, (i == 0) ? 2'h1 : 2'h2);
      chk("ref buffer", {refBufferEnable, panelSupplyOeN}, {!i[1], i[1]});
    end
    wr(REG_CTRL_OFS, 32'h3F, rsp);
    chk("reg on", {regulatedToBiasOne, biasOneSource}, 3'h7);
    chk("trim max", {trimSteps, trimDown}, {TRIM_MAX, 1'b1});
    wr(REG_CTRL_OFS, 32'h06, rsp);
    chk("reg off", {regulatedToBiasOne, biasOneSource, trimSteps, trimDown}, 8'h46);
    wr(8'h14, 32'h1, rsp);
    chk("bad wr", rsp, RESP_SLVERR);
    rd(8'h14, rdv, rsp);
    chk("bad rd resp", rsp, RESP_SLVERR);
    chk("bad rd data", rdv, 32'h0);
  endtask : t_bias
  task automatic t_frame;
    int n;
    wr(DISP_CTRL_TWO_OFS, 32'h1, rsp);
    wr(DISP_CTRL_ONE_OFS, 32'h7, rsp);
    n = 0;
    while (frameIrq !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk("irq up", frameIrq, 1'b1);
    wr(DISP_CTRL_ONE_OFS, 32'h6, rsp);
    wr(DISP_STATUS_OFS, 32'h0, rsp);
    repeat (20) @(posedge clk);
    rd(DISP_STATUS_OFS, rdv, rsp);
    chk("flag held", {rdv[0], frameIrq}, 2'b11);
    wr(DISP_STATUS_OFS, 32'h1, rsp);
    @(posedge clk);
    rd(DISP_STATUS_OFS, rdv, rsp);
    chk("flag clear", {rdv[0], frameIrq}, 2'b00);
    wr(DISP_CTRL_TWO_OFS, 32'h0, rsp);
    wr(DISP_CTRL_ONE_OFS, 32'h7, rsp);
    repeat (20) @(posedge clk);
    rd(DISP_STATUS_OFS, rdv, rsp);
    chk("masked", {rdv[0], frameIrq}, 2'b10);
  endtask : t_frame
  task automatic conclude;
    if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // generous bound; the run needs under two hundred cycles
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    conclude();
  end
  initial begin
    {nrst, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, awprot, arprot} = '0;
    wstrb = 4'hF;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset();
    t_supply();
    t_bias();
    t_frame();
    conclude();
  end
endmodule : lcdsc_supply_ctrl_tb_top
`default_nettype wire
